// ---- twc_params.svh ----
/*
 * Constants of the two-wire controller register slice: addresses, field
 * positions, widths, reset values and the protection key.
 * Assumes it is included by bare name from the package and design files.
 */
`ifndef TWC_PARAMS_SVH
`define TWC_PARAMS_SVH

// ==========================================================================
// Register byte addresses
`define TWC_ADR_IER 32'hf8010024
`define TWC_ADR_IDR 32'hf8010028
`define TWC_ADR_IMR 32'hf801002c
`define TWC_ADR_RHR 32'hf8010030
`define TWC_ADR_THR 32'hf8010034
`define TWC_ADR_WPM 32'hf80100e4
`define TWC_ADR_WPS 32'hf80100e8
`define TWC_ADR_CWG 32'hf8010010
`define TWC_ADR_SMR 32'hf8010008

// ==========================================================================
// Widths and field positions
`define TWC_WORD_W 32
`define TWC_BYTE_W 8
`define TWC_IRQ_W 12
`define TWC_KEY_W 24
`define TWC_KEY_LSB 8
`define TWC_REJ_W 24
`define TWC_REJ_LSB 8
`define TWC_PROT_BIT 0
`define TWC_ERR_BIT 0
`define TWC_FLAG_PAD 7

// ==========================================================================
// Values
`define TWC_KEY 24'h545749
`define TWC_IRQ_VALID 12'hf77
`define TWC_IRQ_RST 12'h000
`define TWC_BYTE_RST 8'h00
`define TWC_WORD_RST 32'h00000000
`define TWC_CWG_RST 32'h00000000
`define TWC_SMR_RST 32'h00000000

`endif

// ---- twc_pkg.sv ----
/*
 * Types shared by the two-wire controller register slice.
 * Assumes twc_params.svh is on the include path.
 */
`default_nettype none
`include "twc_params.svh"

package twc_pkg;
	typedef logic [`TWC_WORD_W-1:0] twc_word_t;
	typedef logic [`TWC_BYTE_W-1:0] twc_byte_t;
	typedef logic [`TWC_IRQ_W-1:0] twc_irq_t;
	typedef enum logic [3:0] {
		TWC_R_NONE = 4'h0,
		TWC_R_IER = 4'h1,
		TWC_R_IDR = 4'h2,
		TWC_R_IMR = 4'h3,
		TWC_R_RHR = 4'h4,
		TWC_R_THR = 4'h5,
		TWC_R_WPM = 4'h6,
		TWC_R_WPS = 4'h7,
		TWC_R_CWG = 4'h8,
		TWC_R_SMR = 4'h9
	} twc_reg_t;
endpackage

`default_nettype wire

// ---- twc_protect_enable_guard.sv ----
/*
 * Keyed write protection for the clock waveform and slave mode registers,
 * with capture of the address of a rejected write.
 * Assumes decoded selects from the register bank on the same clock.
 */
`default_nettype none
`include "twc_params.svh"

module twc_protect_enable_guard
	import twc_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Decoded bus access.
	input wire logic wr_en,
	input wire twc_word_t wr_addr,
	input wire twc_word_t wr_data,
	input wire logic mode_sel,
	input wire logic guarded_sel,
	input wire logic status_rd,
	// Protection state.
	output logic prot_en,
	output logic blocked,
	output logic viol,
	output logic [`TWC_REJ_W-1:0] rej_addr
);

	// ======================================================================
	// Key check and enable bit
	logic prot_q;
	logic prot_d;
	logic viol_q;
	logic viol_d;
	logic [`TWC_REJ_W-1:0] rej_q;
	logic [`TWC_REJ_W-1:0] rej_d;
	wire key_ok = wr_data[`TWC_WORD_W-1:`TWC_KEY_LSB] == `TWC_KEY;
	wire mode_wr = wr_en & mode_sel;

	assign prot_d = (mode_wr & key_ok) ? wr_data[`TWC_PROT_BIT] : prot_q;

	assign blocked = wr_en & guarded_sel & prot_q;

	// ======================================================================
	// Violation record
	// A rejection in the cycle of a status read wins over the clear.
	// flag on rejection.
	assign viol_d = blocked ? 1'b1 : (status_rd ? 1'b0 : viol_q);
	assign rej_d = blocked ? wr_addr[`TWC_REJ_W-1:0] :
		(status_rd ? {`TWC_REJ_W{1'b0}} : rej_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prot_q <= 1'b0;
			viol_q <= 1'b0;
			rej_q <= {`TWC_REJ_W{1'b0}};
		end else begin
			prot_q <= prot_d;
			viol_q <= viol_d;
			rej_q <= rej_d;
		end
	end

	assign prot_en = prot_q;
	assign viol = viol_q;
	assign rej_addr = rej_q;

	// ======================================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_key_mismatch_hold: assert property (
		(mode_wr && !key_ok) |=> $stable(prot_en))
		else $error("protect bit changed without the key");

	a_key_match_load: assert property (
		(mode_wr && key_ok) |=> prot_en == $past(wr_data[`TWC_PROT_BIT]))
		else $error("protect bit not loaded from keyed write");

	a_reject_record: assert property (
		blocked |=> viol && rej_addr == $past(wr_addr[`TWC_REJ_W-1:0]))
		else $error("rejected write not recorded");

	a_reject_flag: assert property (
		(wr_en && guarded_sel && prot_en) |=> viol)
		else $error("violation flag not set on guarded write");

	a_status_clear: assert property (
		(status_rd && !blocked) |=> !viol && rej_addr == '0)
		else $error("status read did not clear the record");

endmodule

`default_nettype wire

// ---- twc_regs.sv ----
/*
 * Register bank of the two-wire controller: interrupt mask with set and
 * clear ports, receive and transmit holding bytes, guarded configuration
 * and keyed write protection.
 * Assumes a protocol engine on REF_CLK that supplies status flags and
 * received bytes and takes transmit bytes; it is not part of this block.
 */
`default_nettype none
`include "twc_params.svh"

module twc_regs
	import twc_pkg::*;
(
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Register bus.
	input wire twc_word_t BUS_ADDR,
	input wire twc_word_t BUS_WDATA,
	input wire logic BUS_WR,
	input wire logic BUS_RD,
	output logic [`TWC_WORD_W-1:0] BUS_RDATA,
	// Protocol engine status and data.
	input wire twc_irq_t STATUS_FLAGS,
	input wire twc_byte_t RX_BYTE,
	input wire logic RX_LOAD,
	output logic RX_TAKEN,
	output logic [`TWC_BYTE_W-1:0] TX_BYTE,
	output logic TX_LOAD,
	// Configuration towards the engine.
	output logic [`TWC_WORD_W-1:0] CLK_WAVE_CFG,
	output logic [`TWC_WORD_W-1:0] SLAVE_MODE_CFG,
	// Interrupt request.
	output logic IRQ
);

	// ======================================================================
	// Address decode
	function automatic twc_reg_t decode(input twc_word_t a);
		twc_reg_t r;
		r = TWC_R_NONE;
		case (a)
			`TWC_ADR_IER: r = TWC_R_IER;
			`TWC_ADR_IDR: r = TWC_R_IDR;
			`TWC_ADR_IMR: r = TWC_R_IMR;
			`TWC_ADR_RHR: r = TWC_R_RHR;
			`TWC_ADR_THR: r = TWC_R_THR;
			`TWC_ADR_WPM: r = TWC_R_WPM;
			`TWC_ADR_WPS: r = TWC_R_WPS;
			`TWC_ADR_CWG: r = TWC_R_CWG;
			`TWC_ADR_SMR: r = TWC_R_SMR;
			default: r = TWC_R_NONE;
		endcase
		return r;
	endfunction

	twc_reg_t sel;
	assign sel = decode(BUS_ADDR);

	wire wr_ier = BUS_WR & (sel == TWC_R_IER);
	wire wr_idr = BUS_WR & (sel == TWC_R_IDR);
	wire wr_thr = BUS_WR & (sel == TWC_R_THR);
	wire wr_cwg = BUS_WR & (sel == TWC_R_CWG);
	wire wr_smr = BUS_WR & (sel == TWC_R_SMR);
	wire rd_rhr = BUS_RD & (sel == TWC_R_RHR);
	wire rd_wps = BUS_RD & (sel == TWC_R_WPS);
	wire guarded_sel = (sel == TWC_R_CWG) | (sel == TWC_R_SMR);

	// ======================================================================
	// Write protection
	logic prot_en;
	logic blocked;
	logic viol;
	logic [`TWC_REJ_W-1:0] rej_addr;

	twc_protect_enable_guard u_guard (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.wr_en(BUS_WR),
		.wr_addr(BUS_ADDR),
		.wr_data(BUS_WDATA),
		.mode_sel(sel == TWC_R_WPM),
		.guarded_sel(guarded_sel),
		.status_rd(rd_wps),
		.prot_en(prot_en),
		.blocked(blocked),
		.viol(viol),
		.rej_addr(rej_addr)
	);

	// ======================================================================
	// Interrupt mask
	twc_irq_t mask_q;
	twc_irq_t mask_d;
	twc_irq_t set_bits;
	twc_irq_t clr_bits;

	// Reserved positions never latch, so they always read back as zero.
	assign set_bits = wr_ier ? (BUS_WDATA[`TWC_IRQ_W-1:0] & `TWC_IRQ_VALID) : '0;
	assign clr_bits = wr_idr ? BUS_WDATA[`TWC_IRQ_W-1:0] : '0;

	genvar gi;
	generate
		for (gi = 0; gi < `TWC_IRQ_W; gi++) begin : g_mask
			assign mask_d[gi] = set_bits[gi] | (mask_q[gi] & ~clr_bits[gi]);
		end
	endgenerate

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_q <= `TWC_IRQ_RST;
		end else begin
			mask_q <= mask_d;
		end
	end

	wire irq_d = |(STATUS_FLAGS & mask_q & `TWC_IRQ_VALID);
	logic irq_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign IRQ = irq_q;

	// ======================================================================
	// Holding bytes
	twc_byte_t rx_q;
	twc_byte_t tx_q;
	logic tx_load_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_q <= `TWC_BYTE_RST;
		end else if (RX_LOAD) begin
			rx_q <= RX_BYTE;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_q <= `TWC_BYTE_RST;
			tx_load_q <= 1'b0;
		end else begin
			tx_load_q <= wr_thr;
			if (wr_thr) begin
				tx_q <= BUS_WDATA[`TWC_BYTE_W-1:0];
			end
		end
	end

	assign TX_BYTE = tx_q;
	assign TX_LOAD = tx_load_q;
	// The engine uses this to drop its receive-ready flag.
	assign RX_TAKEN = rd_rhr;

	// ======================================================================
	// Guarded configuration
	twc_word_t cwg_q;
	twc_word_t smr_q;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cwg_q <= `TWC_CWG_RST;
			smr_q <= `TWC_SMR_RST;
		end else begin
			if (wr_cwg && !blocked) begin
				cwg_q <= BUS_WDATA;
			end
			if (wr_smr && !blocked) begin
				smr_q <= BUS_WDATA;
			end
		end
	end

	assign CLK_WAVE_CFG = cwg_q;
	assign SLAVE_MODE_CFG = smr_q;

	// ======================================================================
	// Read data
	twc_word_t rd_mux;
	twc_word_t imr_view;
	twc_word_t wpm_view;
	twc_word_t wps_view;
	twc_word_t rdata_q;

	assign imr_view = {{(`TWC_WORD_W-`TWC_IRQ_W){1'b0}}, mask_q & `TWC_IRQ_VALID};
	assign wpm_view = {{(`TWC_WORD_W-1){1'b0}}, prot_en};
	assign wps_view = {rej_addr, {`TWC_FLAG_PAD{1'b0}}, viol};

	assign rd_mux =
		(sel == TWC_R_IMR) ? imr_view :
		(sel == TWC_R_RHR) ? {{(`TWC_WORD_W-`TWC_BYTE_W){1'b0}}, rx_q} :
		(sel == TWC_R_THR) ? {{(`TWC_WORD_W-`TWC_BYTE_W){1'b0}}, tx_q} :
		(sel == TWC_R_WPM) ? wpm_view :
		(sel == TWC_R_WPS) ? wps_view :
		(sel == TWC_R_CWG) ? cwg_q :
		(sel == TWC_R_SMR) ? smr_q : `TWC_WORD_RST;

	// Data stands only in the cycle after the read strobe.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= `TWC_WORD_RST;
		end else begin
			rdata_q <= BUS_RD ? rd_mux : `TWC_WORD_RST;
		end
	end

	assign BUS_RDATA = rdata_q;

	// ======================================================================
	// Checks
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_thr_write;
		BUS_WR && sel == TWC_R_THR;
	endsequence

	sequence s_thr_handoff;
		TX_LOAD && TX_BYTE == $past(BUS_WDATA[`TWC_BYTE_W-1:0]);
	endsequence

	// The read that follows a load may itself pulse RX_TAKEN, so only a new load is excluded.
	sequence s_rx_capture;
		RX_LOAD ##1 !RX_LOAD;
	endsequence

	a_mask_set_bits: assert property (
		wr_ier |=> mask_q == ($past(mask_q) | ($past(BUS_WDATA[`TWC_IRQ_W-1:0])
			& `TWC_IRQ_VALID)))
		else $error("enable-set write did not set mask bits");

	a_mask_clear_bits: assert property (
		wr_idr |=> mask_q == ($past(mask_q) & ~$past(BUS_WDATA[`TWC_IRQ_W-1:0])))
		else $error("enable-clear write did not clear mask bits");

	a_mask_view_read: assert property (
		(BUS_RD && sel == TWC_R_IMR) |=> BUS_RDATA == {{(`TWC_WORD_W-`TWC_IRQ_W){1'b0}},
			$past(mask_q)})
		else $error("mask view read mismatch");

	a_mask_reserved_zero: assert property (
		(mask_q & ~`TWC_IRQ_VALID) == '0)
		else $error("reserved mask bit set");

	a_irq_gating: assert property (
		##1 IRQ == |($past(STATUS_FLAGS) & $past(mask_q)))
		else $error("interrupt does not follow flags and mask");

	a_irq_masked_off: assert property (
		(mask_q == '0) |=> !IRQ)
		else $error("interrupt raised with all sources disabled");

	a_rx_byte_view: assert property (
		s_rx_capture ##0 (BUS_RD && sel == TWC_R_RHR) |=>
			BUS_RDATA == {{(`TWC_WORD_W-`TWC_BYTE_W){1'b0}}, $past(RX_BYTE, 2)})
		else $error("receive holding read mismatch");

	a_tx_handoff: assert property (
		s_thr_write |=> s_thr_handoff)
		else $error("transmit byte not handed to shifter");

	a_guard_blocks: assert property (
		((wr_cwg || wr_smr) && prot_en) |=> $stable(CLK_WAVE_CFG) && $stable(SLAVE_MODE_CFG))
		else $error("protected configuration register changed");

	a_rdata_one_cycle: assert property (
		!BUS_RD |=> BUS_RDATA == '0)
		else $error("read data stands outside its cycle");

endmodule

`default_nettype wire

// ---- tb.sv ----
/*
 * Self-checking bench for the two-wire controller register slice.
 * Assumes twc_pkg and twc_regs are compiled first and twc_params.svh is on the include path.
 */
`default_nettype none
`include "twc_params.svh"

module tb
	import twc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================================
	// Signals
	logic REF_CLK;
	logic RST_N;
	twc_word_t BUS_ADDR;
	twc_word_t BUS_WDATA;
	logic BUS_WR;
	logic BUS_RD;
	logic [`TWC_WORD_W-1:0] BUS_RDATA;
	twc_irq_t STATUS_FLAGS;
	twc_byte_t RX_BYTE;
	logic RX_LOAD;
	logic RX_TAKEN;
	logic [`TWC_BYTE_W-1:0] TX_BYTE;
	logic TX_LOAD;
	logic [`TWC_WORD_W-1:0] CLK_WAVE_CFG;
	logic [`TWC_WORD_W-1:0] SLAVE_MODE_CFG;
	logic IRQ;
	int errors;
	int samples_checked;
	int cycles;
	logic rd_pend;
	twc_word_t rq[$];
	twc_byte_t tq[$];
	twc_word_t r;
	twc_word_t m;
	twc_byte_t b;
	twc_word_t ra[5] = '{`TWC_ADR_IMR, `TWC_ADR_RHR, `TWC_ADR_THR, `TWC_ADR_WPM, `TWC_ADR_WPS};

	twc_regs twc_regs_i (
		.REF_CLK(REF_CLK),
		.RST_N(RST_N),
		.BUS_ADDR(BUS_ADDR),
		.BUS_WDATA(BUS_WDATA),
		.BUS_WR(BUS_WR),
		.BUS_RD(BUS_RD),
		.BUS_RDATA(BUS_RDATA),
		.STATUS_FLAGS(STATUS_FLAGS),
		.RX_BYTE(RX_BYTE),
		.RX_LOAD(RX_LOAD),
		.RX_TAKEN(RX_TAKEN),
		.TX_BYTE(TX_BYTE),
		.TX_LOAD(TX_LOAD),
		.CLK_WAVE_CFG(CLK_WAVE_CFG),
		.SLAVE_MODE_CFG(SLAVE_MODE_CFG),
		.IRQ(IRQ)
	);

	initial begin
		REF_CLK = 1'b0;
		forever #4 REF_CLK = ~REF_CLK;
	end

	// ==========================================================================
	// Checks and bus tasks
	task automatic chk(input twc_word_t got, input twc_word_t exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Every strobe is assigned once per op, so back-to-back ops never drive a signal twice.
	task automatic op(input logic w, input logic rd, input logic ld, input twc_word_t a,
			input twc_word_t d);
		if (REF_CLK === 1'b0) @(posedge REF_CLK);
		BUS_WR <= w;
		BUS_RD <= rd;
		RX_LOAD <= ld;
		BUS_ADDR <= a;
		BUS_WDATA <= d;
		@(posedge REF_CLK);
	endtask

	task automatic wr(input twc_word_t a, input twc_word_t d);
		op(1'b1, 1'b0, 1'b0, a, d);
	endtask

	task automatic rd(input twc_word_t a, input twc_word_t e);
		rq.push_back(e);
		op(1'b0, 1'b1, 1'b0, a, 32'h00000000);
	endtask

	task automatic rx(input twc_byte_t v);
		if (REF_CLK === 1'b0) @(posedge REF_CLK);
		RX_BYTE <= v;
		op(1'b0, 1'b0, 1'b1, 32'h00000000, 32'h00000000);
	endtask

	task automatic look(input int n);
		repeat (n) op(1'b0, 1'b0, 1'b0, 32'h00000000, 32'h00000000);
		@(negedge REF_CLK);
	endtask

	task automatic flags(input twc_irq_t f);
		if (REF_CLK === 1'b0) @(posedge REF_CLK);
		STATUS_FLAGS <= f;
	endtask

	task automatic finish_test;
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ==========================================================================
	// Output watcher
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) rd_pend <= 1'b0;
		else rd_pend <= BUS_RD;
	end

	// Read data is only meaningful for one cycle, so it is sampled mid-cycle and zero elsewhere.
	always @(negedge REF_CLK) begin
		if (rd_pend === 1'b1 && rq.size() > 0) chk(BUS_RDATA, rq.pop_front());
		else if (RST_N === 1'b1) chk(BUS_RDATA, `TWC_WORD_RST);
		chk(RX_TAKEN, BUS_RD && BUS_ADDR == `TWC_ADR_RHR);
		if (TX_LOAD === 1'b1 && tq.size() > 0) chk(TX_BYTE, tq.pop_front());
		else if (TX_LOAD === 1'b1) chk(TX_BYTE, 32'hffffffff);
	end

	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			finish_test();
		end
	end

	// ==========================================================================
	// Main sequence
	initial begin
		errors = 0;
		samples_checked = 0;
		cycles = 0;
		RST_N = 1'b0;
		BUS_ADDR = 32'h00000000;
		BUS_WDATA = 32'h00000000;
		BUS_WR = 1'b0;
		BUS_RD = 1'b0;
		RX_LOAD = 1'b0;
		RX_BYTE = 8'h00;
		STATUS_FLAGS = 12'h000;
		r = $urandom(32'hca81);
		repeat (3) @(posedge REF_CLK);
		RST_N <= 1'b1;
		look(1);
		foreach (ra[i]) rd(ra[i], 32'h00000000);
		rd(`TWC_ADR_IER, 32'h00000000);
		rd(32'hf80100ec, 32'h00000000);
		wr(`TWC_ADR_IER, 32'hffffffff);
		rd(`TWC_ADR_IMR, 32'h00000f77);
		r = $urandom();
		wr(`TWC_ADR_IDR, r);
		rd(`TWC_ADR_IMR, 32'h00000f77 & ~r);
		wr(`TWC_ADR_IER, 32'h00000000);
		rd(`TWC_ADR_IMR, 32'h00000f77 & ~r);
		wr(`TWC_ADR_IDR, 32'hffffffff);
		rd(`TWC_ADR_IMR, 32'h00000000);
		for (int i = 0; i < 12; i++) begin
			if (i == 3 || i == 7) continue;
			m = 32'h1 << i;
			flags(~m[11:0]);
			wr(`TWC_ADR_IER, m);
			look(2);
			chk(IRQ, 32'h0);
			flags(m[11:0]);
			look(2);
			chk(IRQ, 32'h1);
			rd(`TWC_ADR_IMR, m);
			wr(`TWC_ADR_IDR, m);
			look(2);
			chk(IRQ, 32'h0);
		end
		for (int k = 0; k < 4; k++) begin
			b = 8'($urandom());
			rx(~b);
			rx(b);
			rd(`TWC_ADR_RHR, {24'h000000, b});
		end
		for (int k = 0; k < 3; k++) begin
			r = $urandom();
			tq.push_back(r[7:0]);
			wr(`TWC_ADR_THR, r);
		end
		rd(`TWC_ADR_THR, {24'h000000, r[7:0]});
		r = $urandom();
		wr(`TWC_ADR_CWG, r);
		wr(`TWC_ADR_SMR, ~r);
		look(1);
		chk(CLK_WAVE_CFG, r);
		chk(SLAVE_MODE_CFG, ~r);
		wr(`TWC_ADR_WPM, {24'h545748, 8'h01});
		rd(`TWC_ADR_WPM, 32'h00000000);
		wr(`TWC_ADR_WPM, {24'h545749, 8'h01});
		rd(`TWC_ADR_WPM, 32'h00000001);
		wr(`TWC_ADR_CWG, r ^ 32'hffff0000);
		rd(`TWC_ADR_WPS, {24'h010010, 8'h01});
		rd(`TWC_ADR_WPS, 32'h00000000);
		wr(`TWC_ADR_SMR, 32'h00000000);
		rd(`TWC_ADR_WPS, {24'h010008, 8'h01});
		look(1);
		chk(CLK_WAVE_CFG, r);
		chk(SLAVE_MODE_CFG, ~r);
		wr(`TWC_ADR_WPM, 32'h00000000);
		rd(`TWC_ADR_WPM, 32'h00000001);
		wr(`TWC_ADR_WPM, {24'h545749, 8'h00});
		rd(`TWC_ADR_WPM, 32'h00000000);
		wr(`TWC_ADR_SMR, r);
		rd(`TWC_ADR_WPS, 32'h00000000);
		look(1);
		chk(SLAVE_MODE_CFG, r);
		look(2);
		chk(32'(rq.size()), 32'h0);
		chk(32'(tq.size()), 32'h0);
		finish_test();
	end
endmodule

`default_nettype wire
